/* File: design/fev_consts.svh */
// Constants for the flash erase-verify sequencer
`ifndef FEV_CONSTS_SVH
`define FEV_CONSTS_SVH
`define FEV_CMD_BLK_VERIFY 8'h02
`define FEV_CMD_SEC_VERIFY 8'h03
`define FEV_IDX_CMD 3'h0
`define FEV_IDX_SEC_ADDR 3'h1
`define FEV_IDX_SEC_CNT 3'h2
`define FEV_SEL_EEPROM 2'h0
`define FEV_SEL_PFLASH 2'h3
`define FEV_CMD_MSB 15
`define FEV_CMD_LSB 8
`define FEV_SEL_MSB 1
`define FEV_SEL_LSB 0
`endif

/* File: design/fev_pkg.sv */
// Types for the flash erase-verify sequencer
`default_nettype none
package fev_pkg;
   typedef enum logic [2:0] {FEV_IDLE, FEV_ISSUE, FEV_WAIT, FEV_DONE} fev_state_e;
   typedef logic [15:0] fev_word_t;
endpackage
`default_nettype wire

/* File: design/fev_range_gen.sv */
// Address range stepper for verify reads
`timescale 1ns/100ps
`default_nettype none
module fev_range_gen #(
   parameter int ADDR_W = 16
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic load,
   input wire logic [ADDR_W-1:0] startAddr,
   input wire logic [ADDR_W-1:0] count,
   input wire logic step,
   output logic [ADDR_W-1:0] curAddr,
   output logic last
);
   logic [ADDR_W-1:0] remain_q;
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         curAddr <= '0;
         remain_q <= '0;
      end
      else if (load)
      begin
         curAddr <= startAddr;
         remain_q <= count;
      end
      else if (step)
      begin
         curAddr <= curAddr + 1'b1;
         remain_q <= remain_q - 1'b1;
      end
   end
   assign last = (remain_q <= 1);
endmodule // fev_range_gen
`default_nettype wire

/* File: design/fev_sequencer.sv */
// Erase-verify command sequencer
// Operation
// RULE1: Block check needs code 0x02 with block select in word index 000.
// RULE2: Select 00 is EEPROM, 11 program flash; 01 and 10 raise access error.
// RULE3: Clearing complete flag launches; every location of the block is checked erased.
// RULE4: Complete flag sets again only after the whole verification finishes.
// RULE5: A non-blank location sets both verify error and uncorrectable bits.
// RULE6: Word index other than 000 at launch sets the access error flag.
// RULE7: An invalid block select code sets the access error flag.
// RULE8: Any read error during the check sets the verify error bit.
// RULE9: Any non-correctable read error sets the uncorrectable bit.
// RULE10: Section check verifies exactly the given start address and phrase count.
// RULE11: On access error skip verification, set complete, keep verify bits.
`timescale 1ns/100ps
`default_nettype none
`include "fev_consts.svh"
module fev_sequencer #(
   parameter int ADDR_W = 16,
   parameter int PF_WORDS = 16'h8000,
   parameter int EE_WORDS = 16'h0100
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic paramWrite,
   input wire logic [2:0] cmdWordIndex,
   input wire logic [15:0] cmdParamWord,
   input wire logic launch,
   input wire logic clearErrors,
   output logic cmdCompleteFlag,
   output logic accessErrorFlag,
   output logic protectViolationFlag,
   output logic verifyErrorBit,
   output logic verifyUncorrectableBit,
   output logic memRead,
   output logic memSelPflash,
   output logic [ADDR_W-1:0] memAddr,
   input wire logic memReady,
   input wire logic memErased,
   input wire logic memReadErr,
   input wire logic memUncorrErr
);
   // Section words are 16 bits, so a wider address could not be loaded
   if (ADDR_W < 1 || ADDR_W > 16 || PF_WORDS < 1 || PF_WORDS >= (1 << ADDR_W)
      || EE_WORDS < 1 || EE_WORDS >= (1 << ADDR_W))
   begin : g_bad_params
      $error("fev_sequencer: block sizes do not fit ADDR_W");
   end

   fev_pkg::fev_word_t words_q [3];
   logic [2:0] idx_q;
   fev_pkg::fev_state_e state_q;
   logic isPflash_q;
   logic load, step, last;
   logic [ADDR_W-1:0] rgStart, rgCount, curAddr;
   logic [7:0] cmd;
   logic [1:0] sel;
   logic selOk, idxOk, isBlk, isSec, access_error_flag;

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         words_q[0] <= '0;
         words_q[1] <= '0;
         words_q[2] <= '0;
         idx_q <= '0;
      end
      else if (paramWrite && cmdCompleteFlag)
      begin
         idx_q <= cmdWordIndex;
         if (cmdWordIndex <= `FEV_IDX_SEC_CNT)
            words_q[cmdWordIndex[1:0]] <= cmdParamWord;
      end
   end

   assign cmd = words_q[0][`FEV_CMD_MSB:`FEV_CMD_LSB];
   assign sel = words_q[0][`FEV_SEL_MSB:`FEV_SEL_LSB];
   assign isBlk = (cmd == `FEV_CMD_BLK_VERIFY); // RULE1
   assign isSec = (cmd == `FEV_CMD_SEC_VERIFY);
   assign selOk = (sel == `FEV_SEL_EEPROM) || (sel == `FEV_SEL_PFLASH); // RULE2 RULE7
   assign idxOk = isBlk ? (idx_q == `FEV_IDX_CMD) : (idx_q == `FEV_IDX_SEC_CNT); // RULE6
   assign access_error_flag = !idxOk || (isBlk && !selOk) || (!isBlk && !isSec)
      || (isSec && words_q[2] == '0);
   // Range chosen per command: whole block, or exactly the section
   assign rgStart = isBlk ? '0 : words_q[1][ADDR_W-1:0]; // RULE10
   assign rgCount = isBlk ? ((sel == `FEV_SEL_PFLASH) ? ADDR_W'(PF_WORDS) : ADDR_W'(EE_WORDS))
      : words_q[2][ADDR_W-1:0]; // RULE3 RULE10
   assign load = (state_q == fev_pkg::FEV_IDLE) && launch && cmdCompleteFlag && !access_error_flag;
   assign step = (state_q == fev_pkg::FEV_WAIT) && memReady && !last;

   fev_range_gen #(.ADDR_W(ADDR_W)) u_range (
      .clock(clock),
      .sys_rst(sys_rst),
      .load(load),
      .startAddr(rgStart),
      .count(rgCount),
      .step(step),
      .curAddr(curAddr),
      .last(last)
   );

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         state_q <= fev_pkg::FEV_IDLE;
         isPflash_q <= 1'b0;
      end
      else
      begin
         unique case (state_q)
            fev_pkg::FEV_IDLE:
               if (load)
               begin
                  state_q <= fev_pkg::FEV_ISSUE;
                  isPflash_q <= !isBlk || (sel == `FEV_SEL_PFLASH); // RULE2
               end
            fev_pkg::FEV_ISSUE:
               state_q <= fev_pkg::FEV_WAIT;
            fev_pkg::FEV_WAIT:
               if (memReady)
                  state_q <= last ? fev_pkg::FEV_DONE : fev_pkg::FEV_ISSUE; // RULE3
            fev_pkg::FEV_DONE:
               state_q <= fev_pkg::FEV_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         memRead <= 1'b0;
         memSelPflash <= 1'b0;
         memAddr <= '0;
      end
      else
      begin
         memRead <= (state_q == fev_pkg::FEV_ISSUE);
         memSelPflash <= isPflash_q;
         memAddr <= curAddr;
      end
   end

   // Complete flag clear is the launch; an access error completes at once
   always_ff @(posedge clock)
   begin
      if (sys_rst)
         cmdCompleteFlag <= 1'b1;
      else if (state_q == fev_pkg::FEV_IDLE && launch && cmdCompleteFlag)
         cmdCompleteFlag <= access_error_flag; // RULE11
      else if (state_q == fev_pkg::FEV_DONE)
         cmdCompleteFlag <= 1'b1; // RULE4
   end

   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         accessErrorFlag <= 1'b0;
         protectViolationFlag <= 1'b0;
      end
      else if (state_q == fev_pkg::FEV_IDLE && launch && cmdCompleteFlag && access_error_flag)
         accessErrorFlag <= 1'b1; // RULE6 RULE7
      else if (clearErrors)
         accessErrorFlag <= 1'b0;
   end

   // Verify bits are cleared at a good launch, then only set during the scan
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         verifyErrorBit <= 1'b0;
         verifyUncorrectableBit <= 1'b0;
      end
      else if (load)
      begin
         verifyErrorBit <= 1'b0;
         verifyUncorrectableBit <= 1'b0;
      end
      else if (state_q == fev_pkg::FEV_WAIT && memReady)
      begin
         if (!memErased || memReadErr)
            verifyErrorBit <= 1'b1; // RULE5 RULE8
         if (!memErased || memUncorrErr)
            verifyUncorrectableBit <= 1'b1; // RULE5 RULE9
      end
   end

   property p_acc_complete;
      @(posedge clock) disable iff (sys_rst)
      (state_q == fev_pkg::FEV_IDLE && launch && cmdCompleteFlag && access_error_flag)
      |=> (cmdCompleteFlag && accessErrorFlag && $stable(verifyErrorBit));
   endproperty
   a_acc_complete: assert property (p_acc_complete) else $error("access error not completed"); // RULE11

   property p_launch_clears;
      @(posedge clock) disable iff (sys_rst)
      load |=> !cmdCompleteFlag && state_q == fev_pkg::FEV_ISSUE;
   endproperty
   a_launch_clears: assert property (p_launch_clears) else $error("launch did not start"); // RULE3

   property p_done_sets;
      @(posedge clock) disable iff (sys_rst)
      !cmdCompleteFlag && state_q != fev_pkg::FEV_DONE |=> !cmdCompleteFlag;
   endproperty
   a_done_sets: assert property (p_done_sets) else $error("complete set early"); // RULE4

   property p_blank_fail;
      @(posedge clock) disable iff (sys_rst)
      (state_q == fev_pkg::FEV_WAIT && memReady && !memErased)
      |=> verifyErrorBit && verifyUncorrectableBit;
   endproperty
   a_blank_fail: assert property (p_blank_fail) else $error("blank fail bits missing"); // RULE5

   property p_read_err;
      @(posedge clock) disable iff (sys_rst)
      (state_q == fev_pkg::FEV_WAIT && memReady && memReadErr) |=> verifyErrorBit;
   endproperty
   a_read_err: assert property (p_read_err) else $error("read error not flagged"); // RULE8

   property p_uncorr_err;
      @(posedge clock) disable iff (sys_rst)
      (state_q == fev_pkg::FEV_WAIT && memReady && memUncorrErr) |=> verifyUncorrectableBit;
   endproperty
   a_uncorr_err: assert property (p_uncorr_err) else $error("uncorrectable not flagged"); // RULE9

   property p_bad_idx;
      @(posedge clock) disable iff (sys_rst)
      (state_q == fev_pkg::FEV_IDLE && launch && cmdCompleteFlag && isBlk
         && idx_q != `FEV_IDX_CMD) |=> accessErrorFlag;
   endproperty
   a_bad_idx: assert property (p_bad_idx) else $error("index error missed"); // RULE6

   property p_bad_sel;
      @(posedge clock) disable iff (sys_rst)
      (state_q == fev_pkg::FEV_IDLE && launch && cmdCompleteFlag && isBlk && !selOk)
      |=> accessErrorFlag && cmdCompleteFlag;
   endproperty
   a_bad_sel: assert property (p_bad_sel) else $error("select error missed"); // RULE7
endmodule // fev_sequencer
`default_nettype wire

/* File: testbench/tb_fev_sequencer.sv */
// Self-checking bench for the erase-verify sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_fev_sequencer;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic paramWrite = 1'b0;
   logic launch = 1'b0;
   logic clearErrors = 1'b0;
   logic [2:0] cmdWordIndex = 3'h0;
   logic [15:0] cmdParamWord = 16'h0000;
   logic memReady = 1'b0;
   logic memErased = 1'b0;
   logic memReadErr = 1'b0;
   logic memUncorrErr = 1'b0;
   logic cmdCompleteFlag, accessErrorFlag, protectViolationFlag;
   logic verifyErrorBit, verifyUncorrectableBit, memRead, memSelPflash;
   logic [15:0] memAddr;
   logic eErr = 1'b0;
   logic eUnc = 1'b0;
   logic selExp = 1'b0;
   int num_errors = 0;
   int checks_done = 0;
   int cycles = 0;
   int reads = 0;
   int dly = 0;
   int curA = 0;
   int mode = 0;
   int badA = 0;
   int baseA = 0;
   int secN = 0;
   always #5 clock = ~clock;
   // Blocks shrunk to four words so a full sweep stays short
   fev_sequencer #(.ADDR_W(16), .PF_WORDS(4), .EE_WORDS(4)) u_fev_sequencer (
      .clock(clock), .sys_rst(sys_rst), .paramWrite(paramWrite),
      .cmdWordIndex(cmdWordIndex), .cmdParamWord(cmdParamWord), .launch(launch),
      .clearErrors(clearErrors), .cmdCompleteFlag(cmdCompleteFlag),
      .accessErrorFlag(accessErrorFlag), .protectViolationFlag(protectViolationFlag),
      .verifyErrorBit(verifyErrorBit), .verifyUncorrectableBit(verifyUncorrectableBit),
      .memRead(memRead), .memSelPflash(memSelPflash), .memAddr(memAddr),
      .memReady(memReady), .memErased(memErased), .memReadErr(memReadErr),
      .memUncorrErr(memUncorrErr));
   task summarize;
      $display("Checks %0d, errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input logic [15:0] g, input logic [15:0] e);
      checks_done++;
      if (g !== e)
      begin
         num_errors++;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task pulse(input logic [2:0] i, input logic [15:0] d, input logic w, input logic l,
      input logic c);
      @(posedge clock);
      paramWrite <= w;
      launch <= l;
      clearErrors <= c;
      cmdWordIndex <= i;
      cmdParamWord <= d;
      @(posedge clock);
      paramWrite <= 1'b0;
      launch <= 1'b0;
      clearErrors <= 1'b0;
   endtask
   task run(input logic [15:0] w0, input int m, input logic xIdx, input logic accExp);
      int n;
      int nExp;
      logic sec;
      sec = (w0[15:8] == 8'h03);
      pulse(3'h0, 16'h0000, 1'b0, 1'b0, 1'b1);
      @(negedge clock);
      chk(16'(accessErrorFlag), 16'h0000);
      pulse(3'h0, w0, 1'b1, 1'b0, 1'b0);
      if (xIdx)
         pulse(3'h1, 16'($urandom), 1'b1, 1'b0, 1'b0);
      baseA = 0;
      nExp = 4;
      // Section start and count go in words 1 and 2, count written last
      if (sec)
      begin
         baseA = $urandom % 16'hFFF0;
         pulse(3'h1, 16'(baseA), 1'b1, 1'b0, 1'b0);
         pulse(3'h2, 16'(secN), 1'b1, 1'b0, 1'b0);
         nExp = secN;
      end
      mode = m;
      badA = $urandom % 4;
      reads = 0;
      selExp = w0[0] || sec;
      if (!accExp)
      begin
         eErr = 1'b0;
         eUnc = 1'b0;
      end
      pulse(3'h0, 16'h0000, 1'b0, 1'b1, 1'b0);
      n = 0;
      @(negedge clock);
      while (cmdCompleteFlag !== 1'b1 && n < 300)
      begin
         @(negedge clock);
         n++;
      end
      repeat (2) @(negedge clock);
      chk(16'(cmdCompleteFlag), 16'h0001);
      chk(16'(reads), accExp ? 16'h0000 : 16'(nExp));
      chk({accessErrorFlag, protectViolationFlag, verifyErrorBit, verifyUncorrectableBit},
         {accExp, 1'b0, eErr, eUnc});
   endtask
   // Memory side answers after a random delay; qualifiers are noise outside memReady
   always @(posedge clock)
   begin
      if (memRead === 1'b1)
      begin
         chk(memAddr, 16'(baseA + reads));
         chk(16'(memSelPflash), 16'(selExp));
         curA = reads;
         reads++;
         dly = $urandom % 3 + 1;
      end
      if (dly == 1)
      begin
         memReady <= 1'b1;
         memErased <= !(mode == 1 && curA == badA);
         memReadErr <= mode > 1 && curA == badA;
         memUncorrErr <= mode == 3 && curA == badA;
         if (mode > 0 && curA == badA)
         begin
            eErr = 1'b1;
            eUnc = eUnc | (mode != 2);
         end
      end
      else
      begin
         memReady <= 1'b0;
         memErased <= 1'($urandom);
         memReadErr <= 1'($urandom);
         memUncorrErr <= 1'($urandom);
      end
      if (dly > 0)
         dly--;
   end
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         num_errors++;
         summarize();
      end
   end
   initial
   begin
      void'($urandom(32'h3fc8));
      repeat (3) @(posedge clock);
      sys_rst <= 1'b0;
      @(negedge clock);
      chk({cmdCompleteFlag, accessErrorFlag, protectViolationFlag, verifyErrorBit,
         verifyUncorrectableBit}, 16'h0010);
      run(16'h0200, 0, 1'b0, 1'b0);
      run(16'h0203, 0, 1'b0, 1'b0);
      // Random block choice gives each fault kind one select, EEPROM or program flash
      for (int m = 1; m < 4; m++)
         run({14'h0080, 2'(($urandom % 2) * 3)}, m, 1'b0, 1'b0);
      run(16'h0201, 0, 1'b0, 1'b1);
      run(16'h0202, 0, 1'b0, 1'b1);
      run(16'h0203, 0, 1'b1, 1'b1);
      run(16'h0500, 0, 1'b0, 1'b1);
      secN = 5;
      run(16'h0300, 1, 1'b0, 1'b0);
      secN = 0;
      run(16'h0300, 0, 1'b0, 1'b1);
      run(16'h0200, 0, 1'b0, 1'b0);
      summarize();
   end
endmodule // tb_fev_sequencer
`default_nettype wire
